// ### include/lic_consts.svh
// Address map, field positions, reset values and source table of the interrupt controller
`ifndef LIC_CONSTS_SVH
`define LIC_CONSTS_SVH

// Register addresses in the register file
`define LIC_ADDR_REQUEST 8'hdc
`define LIC_ADDR_MASK 8'hdd
`define LIC_ADDR_MODE 8'hde
`define LIC_ADDR_PRIO 8'hff

// System mode fields
`define LIC_MODE_GIE 0
`define LIC_MODE_FIE 1
`define LIC_MODE_FSEL_LO 2
`define LIC_MODE_FSEL_HI 4

// Priority register fields
`define LIC_PRIO_ORD_HI 7
`define LIC_PRIO_ORD_MID 4
`define LIC_PRIO_ORD_LO 1
`define LIC_PRIO_A_SEL 0
`define LIC_PRIO_B_SEL 2
`define LIC_PRIO_B_SUB 3
`define LIC_PRIO_C_SEL 5
`define LIC_PRIO_C_SUB 6

// Group order codes on priority bits 7, 4, 1
`define LIC_ORD_B_C_A 3'h1
`define LIC_ORD_C_B_A 3'h5

// Reset values
`define LIC_BYTE_ZERO 8'h00
`define LIC_MODE_RESET 5'h00

// Default source table: 17 sources in vector order
`define LIC_NUM_SOURCES 17
`define LIC_HW_CLEAR_SOURCES 17'h00241
`define LIC_LEVEL_MAP {3'h5, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h3, \
  3'h2, 3'h2, 3'h2, 3'h1, 3'h1, 3'h1, 3'h1, 3'h0, 3'h0}

`endif

// ### include/lic_pkg.sv
// Shared types of the interrupt controller
package lic_pkg;
  localparam int LEVELS = 8;
  typedef logic [2:0] lic_level_type;
  typedef logic [7:0] lic_byte_type;
  // Candidate: valid bit above a level number
  typedef logic [3:0] lic_cand_type;
  typedef enum logic [1:0] {ST_IDLE, ST_SERVICE} lic_state_type;
endpackage

// ### include/lic_prio_if.sv
// Carrier between the controller and its level priority resolver
interface lic_prio_if;
  lic_pkg::lic_byte_type req;
  lic_pkg::lic_byte_type prio;
  logic grant_valid;
  lic_pkg::lic_level_type grant_level;
  modport ctrl (output req, output prio, input grant_valid, input grant_level);
  modport resolver (input req, input prio, output grant_valid, output grant_level);
endinterface

// ### logic/lic_prio_resolver.sv
// Group based priority resolution among the eight unmasked levels
`include "lic_consts.svh"
module lic_prio_resolver (
  // Requests, priority setting and winner
  lic_prio_if.resolver pif
);
  lic_pkg::lic_cand_type cand [lic_pkg::LEVELS];
  lic_pkg::lic_cand_type grp_a;
  lic_pkg::lic_cand_type grp_b;
  lic_pkg::lic_cand_type grp_c;
  lic_pkg::lic_cand_type best;
  logic [2:0] order;

  // Take the preferred candidate if it is valid, else the other
  function automatic lic_pkg::lic_cand_type pick2(input lic_pkg::lic_cand_type a,
                                                  input lic_pkg::lic_cand_type b,
                                                  input logic b_first);
    if (b_first) begin
      pick2 = b[3] ? b : a;
    end else begin
      pick2 = a[3] ? a : b;
    end
  endfunction

  // One candidate per level
  genvar gi;
  generate
    for (gi = 0; gi < lic_pkg::LEVELS; gi++) begin : g_cand
      assign cand[gi] = {pif.req[gi], 3'(gi)};
    end
  endgenerate

  // Winners inside groups A, B and C
  always_comb begin
    grp_a = pick2(cand[0], cand[1], pif.prio[`LIC_PRIO_A_SEL]);
    grp_b = pick2(cand[2], pick2(cand[3], cand[4], pif.prio[`LIC_PRIO_B_SUB]),
                  pif.prio[`LIC_PRIO_B_SEL]);
    grp_c = pick2(cand[5], pick2(cand[6], cand[7], pif.prio[`LIC_PRIO_C_SUB]),
                  pif.prio[`LIC_PRIO_C_SEL]);
    order = {pif.prio[`LIC_PRIO_ORD_HI], pif.prio[`LIC_PRIO_ORD_MID],
             pif.prio[`LIC_PRIO_ORD_LO]};
    case (order)
      `LIC_ORD_B_C_A: best = pick2(grp_b, pick2(grp_c, grp_a, 1'b0), 1'b0);
      `LIC_ORD_C_B_A: best = pick2(grp_c, pick2(grp_b, grp_a, 1'b0), 1'b0);
      default: best = pick2(grp_a, pick2(grp_b, grp_c, 1'b0), 1'b0);
    endcase
  end

  // Winner out
  assign pif.grant_valid = best[3];
  assign pif.grant_level = best[2:0];
endmodule

// ### logic/lic_controller.sv
// Level interrupt controller: pending flags, level mask, priority and mode registers
`include "lic_consts.svh"

// Notes on behaviour
// - Mask bit n at 0 blocks level n, at 1 lets it through.
// - Request register is read only, bit n set while level n requests; zero at reset.
// - Request register keeps recording while global enable is off.
// - No request is raised to the CPU while global enable is clear; level and source outputs still follow the winner.
// - Mode bit 0 is global enable; enable-all sets, disable-all clears, writes too.
// - Reset clears mode bits 1 and 0; bits 4 to 2 need no set value.
// - Mode bits 4 to 2 name the level that gets fast handling.
// - Groups: A is levels 0-1, B is levels 2-4, C is levels 5-7.
// - Priority bits 7, 4 and 1 order the three groups.
// - Order code 001 gives B, C, A; code 101 gives C, B, A.
// - Priority bit 0 orders level 0 against level 1.
// - Priority bit 5 orders group C; bit 6 orders its subgroup.
// - Group order and priority bits pick the level; inside a level the lowest vector wins.
// - Hardware-cleared flags set on request, clear on CPU acknowledge; not visible.
// - Timer A, timer D and PWM overflows are hardware cleared; others software.
// - Software-cleared flags stay set until software writes 0 to them.
// - Request goes out only if enabled, unmasked, winning and source enabled.
// - Acknowledge clears global enable; return from handler sets it again.
// - Mode bit 1 turns fast handling on for the selected level.
module lic_controller #(
  parameter int NSRC = `LIC_NUM_SOURCES,
  parameter logic [NSRC-1:0] HW_CLEAR = `LIC_HW_CLEAR_SOURCES,
  parameter logic [3*NSRC-1:0] LEVEL_MAP = `LIC_LEVEL_MAP,
  localparam int SW = $clog2(NSRC)
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Register file port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // Core instruction strobes
  input wire logic enable_all_instruction_i,
  input wire logic disable_all_instruction_i,
  input wire logic return_from_handler_i,
  input wire logic cpu_acknowledge_i,
  // Peripheral sources
  input wire logic [NSRC-1:0] src_event_i,
  input wire logic [NSRC-1:0] src_enable_i,
  input wire logic [NSRC-1:0] src_sw_clear_i,
  // Request to the core
  output logic irq_o,
  output logic [2:0] irq_level_o,
  output logic [SW-1:0] irq_source_o,
  output logic irq_fast_o,
  output logic in_service_o,
  // Status
  output logic [NSRC-1:0] src_pending_o,
  output logic global_enable_o
);
  // Register file state
  lic_pkg::lic_byte_type mask_reg;
  lic_pkg::lic_byte_type mask_next;
  lic_pkg::lic_byte_type prio_reg;
  lic_pkg::lic_byte_type prio_next;
  logic [4:0] mode_reg;
  logic [4:0] mode_next;
  lic_pkg::lic_byte_type status_reg;
  lic_pkg::lic_byte_type status_next;
  lic_pkg::lic_byte_type rdata_reg;
  lic_pkg::lic_byte_type rdata_next;

  // Source flags
  logic [NSRC-1:0] pend_reg;
  logic [NSRC-1:0] pend_next;
  logic [NSRC-1:0] gated;
  lic_pkg::lic_byte_type level_req;

  // Service sequence state
  lic_pkg::lic_state_type state_reg;
  lic_pkg::lic_state_type state_next;
  logic [SW-1:0] svc_src_reg;
  logic [SW-1:0] svc_src_next;
  logic svc_reg;
  logic svc_next;

  // Outputs to the core
  logic irq_reg;
  logic irq_next;
  lic_pkg::lic_level_type lvl_reg;
  lic_pkg::lic_level_type lvl_next;
  logic [SW-1:0] src_reg;
  logic [SW-1:0] src_next;
  logic fast_reg;
  logic fast_next;

  // Winner search
  logic src_found;
  logic [SW-1:0] src_win;
  logic wr_mask;
  logic wr_mode;
  logic wr_prio;

  lic_prio_if pif ();

  // Level that a source belongs to
  function automatic lic_pkg::lic_level_type src_level(input int idx);
    src_level = LEVEL_MAP[3*idx +: 3];
  endfunction

  // Address match for a register write
  function automatic logic wr_hit(input logic [7:0] addr, input logic [7:0] target,
                                  input logic wr);
    wr_hit = wr && (addr == target);
  endfunction

  // Level priority resolver
  lic_prio_resolver lic_prio_resolver_inst (
    .pif(pif.resolver)
  );

  // Feed the resolver with unmasked level requests
  assign pif.req = level_req & mask_reg;
  assign pif.prio = prio_reg;

  // Write decode
  assign wr_mask = wr_hit(reg_addr_i, `LIC_ADDR_MASK, reg_wr_i);
  assign wr_mode = wr_hit(reg_addr_i, `LIC_ADDR_MODE, reg_wr_i);
  assign wr_prio = wr_hit(reg_addr_i, `LIC_ADDR_PRIO, reg_wr_i);

  // Source flags gated by their enables
  assign gated = pend_reg & src_enable_i;

  // Level requests as OR of gated flags
  always_comb begin
    level_req = `LIC_BYTE_ZERO;
    for (int i = 0; i < NSRC; i++) begin
      if (gated[i]) begin
        level_req[src_level(i)] = 1'b1;
      end
    end
  end

  // Lowest vector of the winning level
  always_comb begin
    src_found = 1'b0;
    src_win = '0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (gated[i] && src_level(i) == pif.grant_level) begin
        src_found = 1'b1;
        src_win = SW'(i);
      end
    end
  end

  // Pending flags: set wins over every clear
  always_comb begin
    pend_next = pend_reg;
    for (int i = 0; i < NSRC; i++) begin
      if (HW_CLEAR[i]) begin
        if (cpu_acknowledge_i && src_reg == SW'(i)) begin
          pend_next[i] = 1'b0;
        end
      end else if (src_sw_clear_i[i]) begin
        pend_next[i] = 1'b0;
      end
      if (src_event_i[i]) begin
        pend_next[i] = 1'b1;
      end
    end
  end

  // Mask, priority and mode registers
  always_comb begin
    mask_next = wr_mask ? reg_wdata_i : mask_reg;
    prio_next = wr_prio ? reg_wdata_i : prio_reg;
    mode_next = mode_reg;
    if (wr_mode) begin
      mode_next = reg_wdata_i[`LIC_MODE_FSEL_HI:0];
    end
    if (disable_all_instruction_i) begin
      mode_next[`LIC_MODE_GIE] = 1'b0;
    end
    if (enable_all_instruction_i || return_from_handler_i) begin
      mode_next[`LIC_MODE_GIE] = 1'b1;
    end
    if (cpu_acknowledge_i) begin
      mode_next[`LIC_MODE_GIE] = 1'b0;
    end
  end

  // Request status and read data
  always_comb begin
    status_next = level_req;
    case (reg_addr_i)
      `LIC_ADDR_REQUEST: rdata_next = status_reg;
      `LIC_ADDR_MASK: rdata_next = mask_reg;
      `LIC_ADDR_MODE: rdata_next = {3'h0, mode_reg};
      `LIC_ADDR_PRIO: rdata_next = prio_reg;
      default: rdata_next = `LIC_BYTE_ZERO;
    endcase
  end

  // Request presented to the core
  always_comb begin
    irq_next = mode_reg[`LIC_MODE_GIE] && pif.grant_valid && src_found
               && !cpu_acknowledge_i;
    lvl_next = pif.grant_valid ? pif.grant_level : lvl_reg;
    src_next = src_found ? src_win : src_reg;
    fast_next = irq_next && mode_reg[`LIC_MODE_FIE]
                && (pif.grant_level == mode_reg[`LIC_MODE_FSEL_HI:`LIC_MODE_FSEL_LO]);
    if (cpu_acknowledge_i) begin
      lvl_next = lvl_reg;
      src_next = src_reg;
    end
  end

  // Service sequence: acknowledge enters, return leaves
  always_comb begin
    state_next = state_reg;
    svc_src_next = svc_src_reg;
    case (state_reg)
      lic_pkg::ST_IDLE: begin
        if (cpu_acknowledge_i && irq_reg) begin
          state_next = lic_pkg::ST_SERVICE;
          svc_src_next = src_reg;
        end
      end
      lic_pkg::ST_SERVICE: begin
        if (return_from_handler_i) begin
          state_next = lic_pkg::ST_IDLE;
        end
      end
      default: state_next = lic_pkg::ST_IDLE;
    endcase
    svc_next = (state_next == lic_pkg::ST_SERVICE);
  end

  // Registers; mask and priority only need a known value
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mask_reg <= `LIC_BYTE_ZERO;
      prio_reg <= `LIC_BYTE_ZERO;
      mode_reg <= `LIC_MODE_RESET;
      status_reg <= `LIC_BYTE_ZERO;
      rdata_reg <= `LIC_BYTE_ZERO;
      pend_reg <= '0;
      state_reg <= lic_pkg::ST_IDLE;
      svc_src_reg <= '0;
      svc_reg <= 1'b0;
      irq_reg <= 1'b0;
      lvl_reg <= '0;
      src_reg <= '0;
      fast_reg <= 1'b0;
    end else begin
      mask_reg <= mask_next;
      prio_reg <= prio_next;
      mode_reg <= mode_next;
      status_reg <= status_next;
      rdata_reg <= rdata_next;
      pend_reg <= pend_next;
      state_reg <= state_next;
      svc_src_reg <= svc_src_next;
      svc_reg <= svc_next;
      irq_reg <= irq_next;
      lvl_reg <= lvl_next;
      src_reg <= src_next;
      fast_reg <= fast_next;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata_o = rdata_reg;
  assign irq_o = irq_reg;
  assign irq_level_o = lvl_reg;
  assign irq_source_o = src_reg;
  assign irq_fast_o = fast_reg;
  assign in_service_o = svc_reg;
  assign src_pending_o = pend_reg & ~HW_CLEAR;
  assign global_enable_o = mode_reg[`LIC_MODE_GIE];
endmodule

// ### dv/lic_controller_props.sv
// Port checker for the level interrupt controller
`include "lic_consts.svh"
module lic_controller_props #(
  parameter int NSRC = 17,
  localparam int SW = $clog2(NSRC)
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  // Core strobes
  input wire logic enable_all_instruction_i,
  input wire logic disable_all_instruction_i,
  input wire logic return_from_handler_i,
  input wire logic cpu_acknowledge_i,
  // Sources
  input wire logic [NSRC-1:0] src_event_i,
  input wire logic [NSRC-1:0] src_enable_i,
  input wire logic [NSRC-1:0] src_sw_clear_i,
  // Request and status
  input wire logic irq_o,
  input wire logic [2:0] irq_level_o,
  input wire logic [SW-1:0] irq_source_o,
  input wire logic irq_fast_o,
  input wire logic in_service_o,
  input wire logic [NSRC-1:0] src_pending_o,
  input wire logic global_enable_o
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [NSRC-1:0] HWC = `LIC_HW_CLEAR_SOURCES;
  localparam logic [3*NSRC-1:0] LMAP = `LIC_LEVEL_MAP;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  // Global enable, service state and request level
  AST_ACK_CLEARS_GIE: assert property (cpu_acknowledge_i |=> !global_enable_o)
    else $error("ack left global enable set");
  AST_ACK_SERVICE: assert property (cpu_acknowledge_i && irq_o |=> !irq_o && in_service_o)
    else $error("ack did not enter service");
  AST_RET_ENDS: assert property (return_from_handler_i && !cpu_acknowledge_i
    |=> global_enable_o && !in_service_o)
    else $error("return did not end service");
  AST_EI_SETS: assert property (enable_all_instruction_i && !cpu_acknowledge_i
    |=> global_enable_o)
    else $error("enable-all ignored");
  AST_DI_CLEARS: assert property (disable_all_instruction_i && !enable_all_instruction_i
    && !return_from_handler_i && !cpu_acknowledge_i |=> !global_enable_o)
    else $error("disable-all ignored");
  AST_NO_IRQ_OFF: assert property (!global_enable_o && !enable_all_instruction_i
    && !return_from_handler_i && !reg_wr_i |=> !irq_o)
    else $error("request while disabled");
  AST_MODE_READ: assert property (reg_addr_i == `LIC_ADDR_MODE
    |=> reg_rdata_o[7:5] == 3'h0 && reg_rdata_o[0] == $past(global_enable_o))
    else $error("mode readback wrong");
  AST_LEVEL_MATCH: assert property (irq_o |-> irq_level_o == LMAP[3*irq_source_o +: 3])
    else $error("level does not match source");
  // Pending flags and fast request
  AST_EVENT_SETS: assert property ((src_event_i & ~HWC) != '0
    |=> (src_pending_o & $past(src_event_i) & ~HWC) == ($past(src_event_i) & ~HWC))
    else $error("event did not set pending");
  AST_SW_HOLDS: assert property ($past(reset_i)
    || (~src_pending_o & $past(src_pending_o) & ~$past(src_sw_clear_i)) == '0)
    else $error("pending dropped without clear");
  AST_HW_HIDDEN: assert property ((src_pending_o & HWC) == '0)
    else $error("hardware flag visible");
  AST_FAST_GATED: assert property (irq_fast_o |-> irq_o)
    else $error("fast without request");
  // Main scenarios
  COV_FAST_ACK: cover property (cpu_acknowledge_i && irq_o && irq_fast_o);
  COV_RETURN: cover property (return_from_handler_i && in_service_o);
  COV_BACK_TO_BACK: cover property (return_from_handler_i ##2 irq_o);
endmodule

// ### dv/lic_cpu_model.sv
// Behavioural core model: acknowledges, clears the flag, returns
module lic_cpu_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Request from the controller
  input wire logic irq_i,
  input wire logic [4:0] source_i,
  // Core strobes
  output logic ack_o,
  output logic ret_o,
  output logic [16:0] clear_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Serves one request at a time, promptly or after idle cycles
  initial begin
    logic [4:0] s;
    ack_o = 1'b0;
    ret_o = 1'b0;
    clear_o = '0;
    forever begin
      @(negedge clk_i);
      if (irq_i && !reset_i) begin
        repeat ($urandom_range(3)) @(negedge clk_i);
        ack_o = 1'b1;
        @(posedge clk_i);
        s = source_i;
        @(negedge clk_i);
        ack_o = 1'b0;
        @(negedge clk_i);
        clear_o[s] = 1'b1;
        @(negedge clk_i);
        clear_o = '0;
        ret_o = 1'b1;
        @(negedge clk_i);
        ret_o = 1'b0;
      end
    end
  end
endmodule

// ### dv/level_interrupt_controller_tb.sv
// Self-checking bench for the level interrupt controller
`include "lic_consts.svh"
module level_interrupt_controller_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
  logic reg_wr_i = 1'b0, enable_all_instruction_i = 1'b0, disable_all_instruction_i = 1'b0;
  logic return_from_handler_i, cpu_acknowledge_i, irq_o, irq_fast_o, in_service_o;
  logic global_enable_o;
  logic [16:0] src_event_i = '0, src_enable_i = '1, src_sw_clear_i, src_pending_o;
  logic [2:0] irq_level_o;
  logic [4:0] irq_source_o;
  logic [8:0] exp_q[$];
  int n_fail = 0, n_checks = 0, cyc = 0;
  // Clock
  always #12.5 clk_i = ~clk_i;
  lic_controller lic_controller_inst (.clk_i, .reset_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i,
    .reg_rdata_o, .enable_all_instruction_i, .disable_all_instruction_i,
    .return_from_handler_i, .cpu_acknowledge_i, .src_event_i, .src_enable_i,
    .src_sw_clear_i, .irq_o, .irq_level_o, .irq_source_o, .irq_fast_o, .in_service_o,
    .src_pending_o, .global_enable_o);
  lic_cpu_model lic_cpu_model_inst (.clk_i, .reset_i, .irq_i(irq_o), .source_i(irq_source_o),
    .ack_o(cpu_acknowledge_i), .ret_o(return_from_handler_i), .clear_o(src_sw_clear_i));
  task automatic check(input string name, input logic [16:0 ] exp, got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic results();
    $display("Checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  function automatic logic [2:0] lvl(input int i);
    return i < 2 ? 3'h0 : i < 6 ? 3'h1 : i < 9 ? 3'h2 : i == 9 ? 3'h3 : i < 16 ? 3'h4 : 3'h5;
  endfunction
  task automatic pulse(ref logic s);
    @(negedge clk_i);
    s = 1'b1;
    @(negedge clk_i);
    s = 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, exp);
    @(negedge clk_i);
    reg_addr_i = a;
    @(negedge clk_i);
    check($sformatf("reg %h", a), {9'h0, exp}, {9'h0, reg_rdata_o});
  endtask
  // Raise events while disabled, enable, then let the core drain them
  task automatic run(input logic [7:0] p, m, input logic [16:0] ev, input int n,
    input logic [19:0] sq);
    wr(`LIC_ADDR_MASK, m);
    wr(`LIC_ADDR_PRIO, p);
    for (int k = 0; k < n; k++) exp_q.push_back({lvl(sq[5*k+:5]) == 3'h2, lvl(sq[5*k+:5]),
      sq[5*k+:5]});
    @(negedge clk_i);
    src_event_i = ev;
    @(negedge clk_i);
    src_event_i = '0;
    pulse(enable_all_instruction_i);
    for (int w = 0; w < 200 && exp_q.size() > 0; w++) @(negedge clk_i);
    repeat (10) @(negedge clk_i);
    pulse(disable_all_instruction_i);
  endtask
  // Timeout and grant scoreboard
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      results();
    end else if (!reset_i && cpu_acknowledge_i && irq_o) begin
      if (exp_q.size() == 0) check("spare grant", 17'h0, 17'h1);
      else check("grant", {8'h0, exp_q.pop_front()},
        {8'h0, irq_fast_o, irq_level_o, irq_source_o});
    end
  end
  // Main sequence
  initial begin
    logic [16:0] en;
    logic [16:0] ev;
    logic [7:0] st;
    void'($urandom(94149));
    repeat (8) @(negedge clk_i);
    reset_i = 1'b0;
    rd(`LIC_ADDR_REQUEST, 8'h00);
    rd(`LIC_ADDR_MODE, 8'h00);
    wr(`LIC_ADDR_MODE, 8'h0a);
    rd(`LIC_ADDR_MODE, 8'h0a);
    wr(`LIC_ADDR_REQUEST, 8'hff);
    rd(`LIC_ADDR_REQUEST, 8'h00);
    rd(8'h10, 8'h00);
    run(8'h00, 8'h02, 17'h0003c, 4, {5'd5, 5'd4, 5'd3, 5'd2});
    run(8'h02, 8'h25, 17'h10041, 3, {5'd0, 5'd0, 5'd16, 5'd6});
    run(8'h82, 8'h25, 17'h10041, 3, {5'd0, 5'd0, 5'd6, 5'd16});
    run(8'h01, 8'h03, 17'h00005, 2, {10'h0, 5'd0, 5'd2});
    run(8'h00, 8'h03, 17'h00005, 2, {10'h0, 5'd2, 5'd0});
    run(8'h00, 8'h01, 17'h00005, 1, {15'h0, 5'd0});
    run(8'h04, 8'h1c, 17'h00640, 3, {5'd0, 5'd6, 5'd10, 5'd9});
    rd(`LIC_ADDR_REQUEST, 8'h02);
    en = 17'($urandom());
    ev = 17'($urandom());
    @(negedge clk_i);
    src_enable_i = en;
    src_event_i = ev;
    @(negedge clk_i);
    src_event_i = '0;
    repeat (3) @(negedge clk_i);
    st = 8'h00;
    for (int i = 0; i < 17; i++) if ((ev[i] || i == 2) && en[i]) st[lvl(i)] = 1'b1;
    rd(`LIC_ADDR_REQUEST, st);
    check("irq while disabled", 17'h0, {16'h0, irq_o});
    check("grants left", 17'h0, 17'(exp_q.size()));
    results();
  end
endmodule
bind lic_controller lic_controller_props #(.NSRC(NSRC)) lic_controller_props_inst (.clk_i,
  .reset_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rdata_o, .enable_all_instruction_i,
  .disable_all_instruction_i, .return_from_handler_i, .cpu_acknowledge_i, .src_event_i,
  .src_enable_i, .src_sw_clear_i, .irq_o, .irq_level_o, .irq_source_o, .irq_fast_o,
  .in_service_o, .src_pending_o, .global_enable_o);
